//--- hdl/bru_pkg.sv
// Purpose: Shared constants and types for the byte rotate unit
// Assumes: 8-bit data path, one clock
// Notes: Operation codes are one-hot, but each decode compares all five bits of the code
package bru_pkg;
  localparam int DATA_W = 8;
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic CARRY_RST = 1'h0;
  localparam logic ZERO_RST = 1'h0;
  localparam logic OVF_RST = 1'h0;

  typedef enum logic [4:0] {
    BRU_OP_ROTATE_LEFT_IN_PLACE = 5'h01,
    BRU_OP_ROTATE_LEFT_TO_RESULT_REG = 5'h02,
    BRU_OP_ROTATE_LEFT_THROUGH_CARRY = 5'h04,
    BRU_OP_ROTATE_LEFT_CARRY_TO_RESULT_REG = 5'h08,
    BRU_OP_ROTATE_RIGHT_IN_PLACE = 5'h10
  } bru_op_t;

  typedef enum logic [1:0] {
    BRU_ST_IDLE = 2'h1,
    BRU_ST_DONE = 2'h2
  } bru_state_t;
endpackage

//--- hdl/bru_rotator.sv
// Purpose: Combinational one-bit rotator with optional carry ring
// Assumes: Caller chooses direction and carry participation
// Notes: No state; shared by all rotate operations
`timescale 1ns/10ps
module bru_rotator (
  // Operand
  input wire logic [bru_pkg::DATA_W-1:0] operand,
  input wire logic carryIn,
  // Control
  input wire logic rotateLeft,
  input wire logic useCarry,
  // Result
  output logic [bru_pkg::DATA_W-1:0] rotated,
  output logic carryOut
);
  wire logic fillLeft;
  wire logic fillRight;

  // Bit that enters the vacated end: old carry or the wrapped bit
  assign fillLeft = useCarry ? carryIn : operand[bru_pkg::MSB_POS];
  assign fillRight = useCarry ? carryIn : operand[bru_pkg::LSB_POS];

  assign rotated = rotateLeft ? {operand[bru_pkg::MSB_POS-1:0], fillLeft}
                              : {fillRight, operand[bru_pkg::MSB_POS:1]};
  // Only meaningful when useCarry is set
  assign carryOut = rotateLeft ? operand[bru_pkg::MSB_POS] : operand[bru_pkg::LSB_POS];
endmodule

//--- hdl/bru_rotate_unit.sv
// Purpose: Single-bit rotate datapath of an 8-bit core
// Assumes: Memory operand and flags are supplied by the core each request
// Notes: Result appears one cycle after the request, all outputs registered
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: Left rotate in place shifts bits up, wraps bit 7 into bit 0, writes memory, flags kept.
// RULE2: Left rotate to the result register does the same rotation, memory untouched, flags kept.
// RULE3: Left rotate through carry forms a nine-bit ring, old carry to bit 0, bit 7 to carry.
// RULE4: Left rotate through carry to the result register does that into the register only.
// RULE5: Right rotate in place shifts bits down, wraps bit 0 into bit 7, writes memory, flags kept.
// RULE6: Operands are 8 bits and only the through-carry operations may change the carry flag.
module bru_rotate_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Request
  input wire logic opValid,
  input wire logic [4:0] opCode,
  input wire logic [bru_pkg::DATA_W-1:0] memData,
  // Flags in
  input wire logic carryFlagIn,
  input wire logic zeroFlagIn,
  input wire logic overflowFlagIn,
  // Memory write-back
  output logic memWrite,
  output logic [bru_pkg::DATA_W-1:0] memWriteData,
  // Result register
  output logic [bru_pkg::DATA_W-1:0] resultReg,
  // Flags out
  output logic carryFlagOut,
  output logic zeroFlagOut,
  output logic overflowFlagOut,
  // Status
  output logic done,
  output logic illegalOp
);
  // Registered state; every output has a flop of its own
  logic memWrite_q;
  logic [bru_pkg::DATA_W-1:0] memWriteData_q;
  logic [bru_pkg::DATA_W-1:0] resultReg_q;
  logic carry_q;
  logic zero_q;
  logic ovf_q;
  logic illegal_q;
  logic done_q;
  bru_pkg::bru_state_t state_q;
  bru_pkg::bru_state_t state_d;

  // Operation decode
  wire logic isLeftPlace;
  wire logic isLeftReg;
  wire logic isLeftCarry;
  wire logic isLeftCarryReg;
  wire logic isRightPlace;
  wire logic legalOp;
  wire logic accept;
  wire logic refuse;

  // Routing controls
  wire logic toMemory;
  wire logic toResult;
  wire logic carryUsed;
  wire logic rotLeft;

  // Datapath
  wire logic [bru_pkg::DATA_W-1:0] rotated;
  wire logic rotCarry;

  // Next register values
  wire logic memWrite_d;
  wire logic [bru_pkg::DATA_W-1:0] memWriteData_d;
  wire logic [bru_pkg::DATA_W-1:0] resultReg_d;
  wire logic carry_d;
  wire logic zero_d;
  wire logic ovf_d;
  wire logic illegal_d;
  wire logic done_d;

  assign isLeftPlace = opCode == bru_pkg::BRU_OP_ROTATE_LEFT_IN_PLACE;
  assign isLeftReg = opCode == bru_pkg::BRU_OP_ROTATE_LEFT_TO_RESULT_REG;
  assign isLeftCarry = opCode == bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY;
  assign isLeftCarryReg = opCode == bru_pkg::BRU_OP_ROTATE_LEFT_CARRY_TO_RESULT_REG;
  assign isRightPlace = opCode == bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE;
  assign legalOp = isLeftPlace | isLeftReg | isLeftCarry | isLeftCarryReg | isRightPlace;
  assign accept = opValid & legalOp;
  // A refused code changes nothing but still reports, so a core can trap it
  assign refuse = opValid & ~legalOp;

  // Destination select: memory or result register, never both
  assign toMemory = isLeftPlace | isLeftCarry | isRightPlace; // see RULE1 RULE3 RULE5
  assign toResult = isLeftReg | isLeftCarryReg; // see RULE2 RULE4
  assign carryUsed = isLeftCarry | isLeftCarryReg; // see RULE3 RULE4
  assign rotLeft = ~isRightPlace; // see RULE5

  // One shared rotator serves every form; only its controls differ
  bru_rotator u_bru_rotator (
    .operand(memData),
    .carryIn(carryFlagIn),
    .rotateLeft(rotLeft),
    .useCarry(carryUsed),
    .rotated(rotated),
    .carryOut(rotCarry)
  );

  // Write-back strobe and data; the data hold between writes
  assign memWrite_d = accept & toMemory; // see RULE1 RULE3 RULE5
  assign memWriteData_d = memWrite_d ? rotated : memWriteData_q; // see RULE1 RULE3 RULE5
  assign resultReg_d = (accept & toResult) ? rotated : resultReg_q; // see RULE2 RULE4
  // Carry moves only for the through-carry forms
  assign carry_d = (accept & carryUsed) ? rotCarry : carry_q; // see RULE6
  // Zero and overflow are echoed from the core, never computed here
  assign zero_d = accept ? zeroFlagIn : zero_q; // see RULE6
  assign ovf_d = accept ? overflowFlagIn : ovf_q; // see RULE6
  assign illegal_d = refuse;
  assign done_d = state_d == bru_pkg::BRU_ST_DONE;

  // Tracks whether the last edge took a request; back to back keeps it in done
  always_comb begin
    state_d = state_q;
    case (state_q)
      bru_pkg::BRU_ST_IDLE: begin
        if (accept) begin
          state_d = bru_pkg::BRU_ST_DONE;
        end
      end
      bru_pkg::BRU_ST_DONE: begin
        if (!accept) begin
          state_d = bru_pkg::BRU_ST_IDLE;
        end
      end
      default: begin
        state_d = bru_pkg::BRU_ST_IDLE;
      end
    endcase
  end

  // Short flops, one per register, so each reset value sits beside its signal
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= bru_pkg::BRU_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      memWrite_q <= 1'h0;
    end else begin
      memWrite_q <= memWrite_d; // see RULE1 RULE3 RULE5
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      memWriteData_q <= bru_pkg::RESULT_RST;
    end else begin
      memWriteData_q <= memWriteData_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resultReg_q <= bru_pkg::RESULT_RST;
    end else begin
      resultReg_q <= resultReg_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      carry_q <= bru_pkg::CARRY_RST;
    end else begin
      carry_q <= carry_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zero_q <= bru_pkg::ZERO_RST;
    end else begin
      zero_q <= zero_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_q <= bru_pkg::OVF_RST;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // Pulses for one cycle per refused request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      illegal_q <= 1'h0;
    end else begin
      illegal_q <= illegal_d;
    end
  end

  // Rises the cycle after every accepted request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_q <= 1'h0;
    end else begin
      done_q <= done_d;
    end
  end

  // Non-carry ops hold carry_q, so a core must present its current carry
  // on carryFlagIn; the held copy is what carryFlagOut reports.
  assign memWrite = memWrite_q;
  assign memWriteData = memWriteData_q;
  assign resultReg = resultReg_q;
  assign carryFlagOut = carry_q;
  assign zeroFlagOut = zero_q;
  assign overflowFlagOut = ovf_q;
  assign done = done_q;
  assign illegalOp = illegal_q;
endmodule

//--- dv/bru_checker.sv
// Purpose: Port assertions for the rotate unit
// Assumes: Results land one cycle after a request
// Notes: Bound from tb
`timescale 1ns/10ps
module bru_checker (
  // Clock, reset, request
  input wire logic clock,
  input wire logic rst,
  input wire logic opValid,
  input wire logic [4:0] opCode,
  input wire logic [7:0] memData,
  input wire logic carryFlagIn,
  input wire logic zeroFlagIn,
  input wire logic overflowFlagIn,
  // Results
  input wire logic memWrite,
  input wire logic [7:0] memWriteData,
  input wire logic [7:0] resultReg,
  input wire logic carryFlagOut,
  input wire logic zeroFlagOut,
  input wire logic overflowFlagOut,
  input wire logic done,
  input wire logic illegalOp
);
  wire logic legalCode;
  assign legalCode = opCode inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_op(logic [4:0] c); opValid && opCode == c; endsequence
  sequence s_take; opValid && legalCode; endsequence
  property p_rl; s_op(5'h01) |=>
    memWrite && memWriteData == (($past(memData) << 1) | ($past(memData) >> 7)); endproperty
  a_rl: assert property (p_rl) else $error("left in place");
  property p_rla; s_op(5'h02) |=>
    !memWrite && resultReg == (($past(memData) << 1) | ($past(memData) >> 7)); endproperty
  a_rla: assert property (p_rla) else $error("left to result");
  property p_rlc; s_op(5'h04) |=>
    memWrite && {carryFlagOut, memWriteData} == {$past(memData), $past(carryFlagIn)}; endproperty
  a_rlc: assert property (p_rlc) else $error("left carry");
  property p_rlca; s_op(5'h08) |=>
    !memWrite && {carryFlagOut, resultReg} == {$past(memData), $past(carryFlagIn)}; endproperty
  a_rlca: assert property (p_rlca) else $error("left carry result");
  property p_rr; s_op(5'h10) |=>
    memWrite && memWriteData == (($past(memData) >> 1) | ($past(memData) << 7)); endproperty
  a_rr: assert property (p_rr) else $error("right in place");
  property p_fl; s_take |=> done && !illegalOp &&
    zeroFlagOut == $past(zeroFlagIn) && overflowFlagOut == $past(overflowFlagIn); endproperty
  a_fl: assert property (p_fl) else $error("flags not echoed");
  property p_fh; !(opValid && legalCode) |=> !done && !memWrite && $stable(resultReg) &&
    $stable(zeroFlagOut) && $stable(overflowFlagOut); endproperty
  a_fh: assert property (p_fh) else $error("state moved without request");
  property p_il; opValid && !legalCode |=> illegalOp && !done && !memWrite; endproperty
  a_il: assert property (p_il) else $error("refused code not flagged");
  property p_ck; !(opValid && opCode inside {5'h04, 5'h08}) |=>
    $stable(carryFlagOut); endproperty
  a_ck: assert property (p_ck) else $error("carry moved");
endmodule

//--- dv/tb.sv
// Purpose: Self-checking bench for the rotate unit
// Assumes: Inputs move on the falling edge
// Notes: Requests run back to back
`timescale 1ns/10ps
module tb;
  logic clock = 1'h0, rst = 1'h1, opValid = 1'h0, carryFlagIn = 1'h0;
  logic zeroFlagIn = 1'h0, overflowFlagIn = 1'h0, ec = 1'h0;
  logic [4:0] opCode = 5'h00;
  logic [7:0] memData = 8'h00, memWriteData, resultReg;
  logic memWrite, carryFlagOut, zeroFlagOut, overflowFlagOut, done, illegalOp;
  int failures = 0, tests_run = 0;
  bru_rotate_unit u_bru_rotate_unit (
    .clock(clock),
    .rst(rst),
    .opValid(opValid),
    .opCode(opCode),
    .memData(memData),
    .carryFlagIn(carryFlagIn),
    .zeroFlagIn(zeroFlagIn),
    .overflowFlagIn(overflowFlagIn),
    .memWrite(memWrite),
    .memWriteData(memWriteData),
    .resultReg(resultReg),
    .carryFlagOut(carryFlagOut),
    .zeroFlagOut(zeroFlagOut),
    .overflowFlagOut(overflowFlagOut),
    .done(done),
    .illegalOp(illegalOp)
  );
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Starts at a falling edge and ends at the next, so calls chain with no gap
  task automatic run(input logic [4:0] c, input logic [7:0] d, input logic ci,
    input logic [7:0] e);
    {opValid, opCode, memData, carryFlagIn} = {1'b1, c, d, ci};
    @(negedge clock);
    check({illegalOp, done, memWrite, carryFlagOut, c[1] | c[3] ? resultReg : memWriteData},
      {2'h1, ~(c[1] | c[3]), ec, e});
  endtask
  task automatic t_plain;
    for (int i = 0; i < 8; i++) begin
      run(5'h01, 8'h01 << i, ~ec, 8'h01 << (i + 1) % 8);
      run(5'h10, 8'h80 >> i, ~ec, 8'h80 >> (i + 1) % 8);
    end
    run(5'h02, 8'h96, ~ec, 8'h2D);
  endtask
  task automatic t_ring;
    logic [8:0] r, n;
    r = 9'h0A5;
    for (int i = 0; i < 9; i++) begin
      n = {r[7:0], r[8]};
      ec = n[8];
      run(i[0] ? 5'h08 : 5'h04, r[7:0], r[8], n[7:0]);
      r = n;
    end
  endtask
  task automatic t_flags;
    {zeroFlagIn, overflowFlagIn} = 2'h2;
    run(5'h01, 8'h3C, ~ec, 8'h78);
    check({10'h000, zeroFlagOut, overflowFlagOut}, 12'h002);
  endtask
  // Flags seen by a refused request must not reach the outputs
  task automatic t_illegal;
    {opValid, opCode, zeroFlagIn, overflowFlagIn} = {1'h1, 5'h03, 2'h1};
    @(negedge clock);
    opValid = 1'h0;
    check({illegalOp, done, memWrite, carryFlagOut, 8'h00}, {3'h4, ec, 8'h00});
    check({10'h000, zeroFlagOut, overflowFlagOut}, 12'h002);
  endtask
  // Reset in mid-run after a carry write, then a request on the first edge after release
  task automatic t_reset;
    ec = 1'h1;
    run(5'h04, 8'hC0, 1'h1, 8'h81);
    {rst, opValid} = 2'h2;
    @(negedge clock);
    check({illegalOp, done, memWrite, carryFlagOut, memWriteData}, 12'h000);
    check({2'h0, resultReg, zeroFlagOut, overflowFlagOut}, 12'h000);
    {rst, ec} = 2'h0;
    run(5'h02, 8'h81, 1'h1, 8'h03);
    opValid = 1'h0;
  endtask
  initial forever #4 clock = ~clock;
  // About thirty cycles of work after a 20-cycle reset; the limit leaves wide margin
  initial begin
    #20000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'h0;
    @(negedge clock);
    t_plain;
    t_ring;
    t_flags;
    t_illegal;
    t_reset;
    stop_test;
  end
endmodule
bind bru_rotate_unit bru_checker u_bru_checker (
  .clock(clock),
  .rst(rst),
  .opValid(opValid),
  .opCode(opCode),
  .memData(memData),
  .carryFlagIn(carryFlagIn),
  .zeroFlagIn(zeroFlagIn),
  .overflowFlagIn(overflowFlagIn),
  .memWrite(memWrite),
  .memWriteData(memWriteData),
  .resultReg(resultReg),
  .carryFlagOut(carryFlagOut),
  .zeroFlagOut(zeroFlagOut),
  .overflowFlagOut(overflowFlagOut),
  .done(done),
  .illegalOp(illegalOp)
);
